// ---- rtl/dprb_bank.sv ----
`timescale 1ns/1ps

// Functional notes
// - upper profiles are six bytes: 32-bit tuning word, 14-bit phase, two open bits
// - flagged control bits act right after their byte is written, no commit needed
// - serial addresses 0 through 16 are decoded, seventeen locations
// - address five holds no register; host must not use it
// - each address moves exactly its own register's byte count
// - bit zero is the lsb; ranges run high index down to low
// - written bits other than the flagged ones wait in a buffer until the commit strobe pulses
// - internal-profile bit picks control field [22:20], else the profile pins
module dprb_bank
    import dprb_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    // device pins
    input wire logic IO_UPDATE,
    input wire logic [2:0] PROFILE_PINS,
    // byte port from the serial shifter
    input wire logic INSTR_VALID,
    input wire logic INSTR_READ,
    input wire logic [4:0] INSTR_ADDR,
    input wire logic BYTE_VALID,
    input wire logic [7:0] BYTE_IN,
    output logic [7:0] BYTE_OUT,
    output logic XFER_BUSY,
    output logic XFER_DONE,
    output logic ADDR_ERR,
    // active state towards the core
    output logic [31:0] CTRL_ACTIVE,
    output logic [2:0] ACTIVE_PROFILE,
    output logic PROFILE_IN_BANK,
    output logic [31:0] FTW_OUT,
    output logic [13:0] POW_OUT
);

    // bytes per address; zero marks an address with no register
    function automatic logic [2:0] depth_of(input logic [4:0] a);
        if (a > ADDR_LAST || a == ADDR_UNUSED) begin
            return DEPTH_NONE;
        end else if (a == ADDR_CTRL) begin
            return DEPTH_CTRL;
        end else if (a >= ADDR_FIRST_PROF) begin
            return DEPTH_PROF;
        end
        return DEPTH_OTHER;
    endfunction : depth_of

    // byte slot addressed by the running count, honouring byte order
    function automatic logic [5:0] slot_of(input logic [2:0] cnt, input logic [2:0] dep,
                                           input logic lsb_first);
        logic [2:0] pos;
        pos = lsb_first ? cnt : 3'(dep - 3'h1 - cnt);
        return {pos, 3'b000};
    endfunction : slot_of

    // pin synchronisers, three stages, accepted once stages two and three agree
    logic [3:0] s1_r, s2_r, s3_r, pin_r;
    logic [3:0] pin_nxt;
    always_comb begin
        pin_nxt = pin_r;
        if (s2_r == s3_r) begin
            pin_nxt = s3_r;
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            s3_r <= 4'h0;
            pin_r <= 4'h0;
        end else if (CLK_EN) begin
            s1_r <= {IO_UPDATE, PROFILE_PINS};
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    // main state
    dprb_xfer_e st_r, st_nxt;
    logic rd_r, rd_nxt;
    logic lsb_r, lsb_nxt;
    logic [4:0] addr_r, addr_nxt;
    logic [2:0] cnt_r, cnt_nxt, dep_r, dep_nxt;
    logic commit_r, commit_nxt;
    logic [31:0] ctrl_buf_r, ctrl_buf_nxt, ctrl_act_r, ctrl_act_nxt;
    dprb_prof_s prof_buf_r [3], prof_buf_nxt [3], prof_act_r [3], prof_act_nxt [3];
    logic [7:0] byte_out_nxt;
    logic busy_nxt, done_nxt, err_nxt, in_bank_nxt;
    logic [2:0] prof_sel_nxt;
    logic [31:0] ftw_nxt;
    logic [13:0] pow_nxt;
    logic [5:0] slot;
    logic [1:0] pidx;
    logic [47:0] pv;
    dprb_prof_s psel;

    always_comb begin
        st_nxt = st_r;
        rd_nxt = rd_r;
        lsb_nxt = lsb_r;
        addr_nxt = addr_r;
        cnt_nxt = cnt_r;
        dep_nxt = dep_r;
        ctrl_buf_nxt = ctrl_buf_r;
        ctrl_act_nxt = ctrl_act_r;
        prof_buf_nxt = prof_buf_r;
        prof_act_nxt = prof_act_r;
        done_nxt = 1'b0;
        err_nxt = 1'b0;
        byte_out_nxt = 8'h00;
        // order held per transfer, so an immediate order flip cannot land a byte twice
        slot = slot_of(cnt_r, dep_r, lsb_r);
        pidx = 2'(addr_r - ADDR_PROF_FIVE);
        pv = prof_buf_r[pidx];
        // rising edge of the filtered update pin
        commit_nxt = pin_nxt[3] & ~pin_r[3];
        // commit: everything moves at once, one edge after the strobe is seen
        if (commit_r) begin
            ctrl_act_nxt = ctrl_buf_r;
            prof_act_nxt = prof_buf_r;
        end
        unique case (st_r)
            XF_IDLE: begin
                if (INSTR_VALID) begin
                    dep_nxt = depth_of(INSTR_ADDR);
                    addr_nxt = INSTR_ADDR;
                    rd_nxt = INSTR_READ;
                    lsb_nxt = ctrl_act_r[LSB_FIRST_BIT];
                    cnt_nxt = 3'h0;
                    if (depth_of(INSTR_ADDR) == DEPTH_NONE) begin
                        err_nxt = 1'b1;
                    end else begin
                        st_nxt = XF_BUSY;
                    end
                end
            end
            XF_BUSY: begin
                if (addr_r == ADDR_CTRL) begin
                    byte_out_nxt = ctrl_buf_r[slot[4:0] +: 8];
                end else if (addr_r >= ADDR_PROF_FIVE) begin
                    byte_out_nxt = pv[slot +: 8];
                end
                if (BYTE_VALID) begin
                    if (!rd_r && addr_r == ADDR_CTRL) begin
                        ctrl_buf_nxt[slot[4:0] +: 8] = BYTE_IN;
                        // flagged bits skip the buffer stage; newer than any commit
                        ctrl_act_nxt = (ctrl_act_nxt & ~CTRL_IMMEDIATE_MASK)
                                     | (ctrl_buf_nxt & CTRL_IMMEDIATE_MASK);
                    end else if (!rd_r && addr_r >= ADDR_PROF_FIVE) begin
                        pv[slot +: 8] = BYTE_IN;
                        pv[OPEN_LSB +: 2] = 2'b00;
                        prof_buf_nxt[pidx] = dprb_prof_s'(pv);
                    end
                    cnt_nxt = 3'(cnt_r + 3'h1);
                    if (cnt_r == 3'(dep_r - 3'h1)) begin
                        st_nxt = XF_IDLE;
                        done_nxt = 1'b1;
                    end
                end
            end
        endcase
        busy_nxt = (st_nxt == XF_BUSY);
        // profile choice: internal field or pins
        prof_sel_nxt = ctrl_act_r[USE_INT_PROF_BIT] ?
                       ctrl_act_r[INT_PROF_LSB +: 3] : pin_r[2:0];
        in_bank_nxt = (prof_sel_nxt >= FIRST_UPPER_PROF);
        psel = prof_act_r[2'(prof_sel_nxt - FIRST_UPPER_PROF)];
        ftw_nxt = in_bank_nxt ? psel.ftw : 32'h0000_0000;
        pow_nxt = in_bank_nxt ? psel.pow : 14'h0000;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            st_r <= XF_IDLE;
            rd_r <= 1'b0;
            lsb_r <= 1'b0;
            addr_r <= 5'h00;
            cnt_r <= 3'h0;
            dep_r <= 3'h0;
            commit_r <= 1'b0;
            ctrl_buf_r <= CTRL_RESET;
            ctrl_act_r <= CTRL_RESET;
            for (int i = 0; i < 3; i++) begin
                prof_buf_r[i] <= PROF_RESET;
                prof_act_r[i] <= PROF_RESET;
            end
            BYTE_OUT <= 8'h00;
            XFER_BUSY <= 1'b0;
            XFER_DONE <= 1'b0;
            ADDR_ERR <= 1'b0;
            CTRL_ACTIVE <= CTRL_RESET;
            ACTIVE_PROFILE <= 3'h0;
            PROFILE_IN_BANK <= 1'b0;
            FTW_OUT <= 32'h0000_0000;
            POW_OUT <= 14'h0000;
        end else if (CLK_EN) begin
            st_r <= st_nxt;
            rd_r <= rd_nxt;
            lsb_r <= lsb_nxt;
            addr_r <= addr_nxt;
            cnt_r <= cnt_nxt;
            dep_r <= dep_nxt;
            commit_r <= commit_nxt;
            ctrl_buf_r <= ctrl_buf_nxt;
            ctrl_act_r <= ctrl_act_nxt;
            prof_buf_r <= prof_buf_nxt;
            prof_act_r <= prof_act_nxt;
            BYTE_OUT <= byte_out_nxt;
            XFER_BUSY <= busy_nxt;
            XFER_DONE <= done_nxt;
            ADDR_ERR <= err_nxt;
            CTRL_ACTIVE <= ctrl_act_r;
            ACTIVE_PROFILE <= prof_sel_nxt;
            PROFILE_IN_BANK <= in_bank_nxt;
            FTW_OUT <= ftw_nxt;
            POW_OUT <= pow_nxt;
        end
    end

    // flattened views for checking
    logic [143:0] act_flat, buf_flat;
    assign act_flat = {prof_act_r[2], prof_act_r[1], prof_act_r[0]};
    assign buf_flat = {prof_buf_r[2], prof_buf_r[1], prof_buf_r[0]};

    open_bits_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        buf_flat[47:46] == 2'b00 && buf_flat[95:94] == 2'b00 && buf_flat[143:142] == 2'b00)
        else $error("open profile bits not zero");
    immediate_bit_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && st_r == XF_BUSY && BYTE_VALID && !rd_r && addr_r == ADDR_CTRL
        && slot == 6'h10 |=> ctrl_act_r[LSB_FIRST_BIT] == $past(BYTE_IN[7]))
        else $error("immediate control bit did not apply");
    addr_range_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && st_r == XF_IDLE && INSTR_VALID && INSTR_ADDR > ADDR_LAST
        |=> ADDR_ERR && st_r == XF_IDLE)
        else $error("out of range address accepted");
    unused_addr_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && st_r == XF_IDLE && INSTR_VALID && INSTR_ADDR == ADDR_UNUSED
        |=> ADDR_ERR && !XFER_BUSY)
        else $error("address five accepted");
    prof_depth_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && st_r == XF_IDLE && INSTR_VALID && INSTR_ADDR >= ADDR_FIRST_PROF
        && INSTR_ADDR <= ADDR_LAST |=> dep_r == DEPTH_PROF && XFER_BUSY)
        else $error("profile depth wrong");
    xfer_end_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && st_r == XF_BUSY && BYTE_VALID && cnt_r == 3'(dep_r - 3'h1)
        |=> XFER_DONE && !XFER_BUSY ##1 !XFER_DONE || !CLK_EN)
        else $error("transfer did not end at depth");
    hold_buffer_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        !commit_r |=> $stable(act_flat))
        else $error("active profile changed without commit");
    commit_copy_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN && commit_r |=> act_flat == $past(buf_flat))
        else $error("commit did not copy buffers");
    profile_select_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        CLK_EN |=> ACTIVE_PROFILE == ($past(ctrl_act_r[USE_INT_PROF_BIT]) ?
        $past(ctrl_act_r[INT_PROF_LSB +: 3]) : $past(pin_r[2:0])))
        else $error("active profile source wrong");

    write_prof_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
        XFER_DONE && !rd_r && addr_r == ADDR_PROF_SEVEN);
    commit_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
        commit_r && CLK_EN);
    internal_prof_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ctrl_act_r[USE_INT_PROF_BIT] && PROFILE_IN_BANK);

endmodule : dprb_bank

// ---- rtl/dprb_pkg.sv ----
package dprb_pkg;

    // serial address space
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_UNUSED = 5'h05;
    localparam logic [4:0] ADDR_FIRST_PROF = 5'h09;
    localparam logic [4:0] ADDR_PROF_FIVE = 5'h0e;
    localparam logic [4:0] ADDR_PROF_SIX = 5'h0f;
    localparam logic [4:0] ADDR_PROF_SEVEN = 5'h10;
    localparam logic [4:0] ADDR_LAST = 5'h10;

    // byte depths per register
    localparam logic [2:0] DEPTH_NONE = 3'h0;
    localparam logic [2:0] DEPTH_CTRL = 3'h4;
    localparam logic [2:0] DEPTH_PROF = 3'h6;
    localparam logic [2:0] DEPTH_OTHER = 3'h4;

    // primary control register fields
    localparam int USE_INT_PROF_BIT = 27;
    localparam int LSB_FIRST_BIT = 23;
    localparam int INT_PROF_LSB = 20;
    localparam logic [31:0] CTRL_IMMEDIATE_MASK = 32'h0080_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // profile register layout
    localparam int FTW_LSB = 0;
    localparam int POW_LSB = 32;
    localparam int OPEN_LSB = 46;
    localparam logic [47:0] PROF_RESET = 48'h0000_0000_0000;
    localparam logic [2:0] FIRST_UPPER_PROF = 3'h5;

    typedef struct packed {
        logic [1:0] open_bits;
        logic [13:0] pow;
        logic [31:0] ftw;
    } dprb_prof_s;

    typedef enum logic {
        XF_IDLE = 1'b0,
        XF_BUSY = 1'b1
    } dprb_xfer_e;

endpackage : dprb_pkg

// ---- tb/dprb_host.sv ----
`timescale 1ns/1ps
// host model: drives the byte port, commit pin and profile pins
module dprb_host
    import dprb_pkg::*;
(
    // clock
    input wire logic clk,
    // byte port
    output logic instr_valid,
    output logic instr_read,
    output logic [4:0] instr_addr,
    output logic byte_valid,
    output logic [7:0] byte_in,
    input wire logic [7:0] byte_out,
    input wire logic xfer_done,
    input wire logic addr_err,
    // device pins
    output logic io_update,
    output logic [2:0] profile_pins
);
    // quiet port from time zero
    initial begin
        instr_valid = 1'b0;
        instr_read = 1'b0;
        instr_addr = 5'h00;
        byte_valid = 1'b0;
        byte_in = 8'h00;
        io_update = 1'b0;
        profile_pins = 3'h0;
    end

    // one transfer; two wait cycles before each read byte let read data settle
    task automatic xfer(input logic rd, input logic [4:0] a, input int n, input logic lsb,
                        input logic [47:0] wd, output logic [47:0] q, output logic err,
                        output logic done);
        int k;
        q = 48'h0;
        done = 1'b0;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_read <= rd;
        instr_addr <= a;
        @(posedge clk);
        instr_valid <= 1'b0;
        @(negedge clk);
        err = addr_err;
        if (err !== 1'b1) begin // no bytes to a refused address
            for (int i = 0; i < n; i++) begin // exactly the register depth
                k = lsb ? i : n - 1 - i;
                if (rd) begin
                    repeat (2) @(posedge clk);
                    @(negedge clk);
                    q[8*k +: 8] = byte_out;
                end
                @(posedge clk);
                byte_valid <= 1'b1;
                byte_in <= wd[8*k +: 8];
                @(posedge clk);
                byte_valid <= 1'b0;
            end
            @(negedge clk);
            done = xfer_done;
        end
    endtask : xfer

    // commit pulse, held past the pin filter
    task automatic commit();
        @(posedge clk);
        io_update <= 1'b1;
        repeat (8) @(posedge clk);
        io_update <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask : commit

    // profile pins change just after an edge
    task automatic set_pins(input logic [2:0] p);
        @(posedge clk);
        profile_pins <= p;
    endtask : set_pins
endmodule : dprb_host

// ---- tb/dds_profile_register_bank_tb_top.sv ----
`timescale 1ns/1ps
module dds_profile_register_bank_tb_top
    import dprb_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset_n, clk_en, io_update, instr_valid, instr_read, byte_valid;
    logic xfer_busy, xfer_done, addr_err, profile_in_bank, err, done;
    logic [2:0] profile_pins, active_profile;
    logic [4:0] instr_addr;
    logic [7:0] byte_in, byte_out;
    logic [31:0] ctrl_active, ftw_out;
    logic [13:0] pow_out;
    logic [47:0] q;
    int err_count, samples_checked;
    // top bits 7:6 are set on purpose in the first two values, bit 6 only in the third; they must be dropped
    logic [47:0] pv [3] = '{48'hc123_4567_89ab, 48'hfedc_ba98_7654, 48'h5a5a_0f0f_3c3c};
    localparam logic [47:0] MASK = 48'h3fff_ffff_ffff;

    always #12.5 core_clk = ~core_clk;

    dprb_bank dut (.CORE_CLK(core_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
        .IO_UPDATE(io_update), .PROFILE_PINS(profile_pins), .INSTR_VALID(instr_valid),
        .INSTR_READ(instr_read), .INSTR_ADDR(instr_addr), .BYTE_VALID(byte_valid),
        .BYTE_IN(byte_in), .BYTE_OUT(byte_out), .XFER_BUSY(xfer_busy), .XFER_DONE(xfer_done),
        .ADDR_ERR(addr_err), .CTRL_ACTIVE(ctrl_active), .ACTIVE_PROFILE(active_profile),
        .PROFILE_IN_BANK(profile_in_bank), .FTW_OUT(ftw_out), .POW_OUT(pow_out));

    dprb_host host (.clk(core_clk), .instr_valid(instr_valid), .instr_read(instr_read),
        .instr_addr(instr_addr), .byte_valid(byte_valid), .byte_in(byte_in),
        .byte_out(byte_out), .xfer_done(xfer_done), .addr_err(addr_err),
        .io_update(io_update), .profile_pins(profile_pins));

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic wr(input logic [4:0] a, input int n, input logic [47:0] d, input logic l);
        host.xfer(1'b0, a, n, l, d, q, err, done);
        check(48'({err, done, xfer_busy}), 48'h2);
    endtask : wr

    task automatic rd(input logic [4:0] a, input int n, input logic l, input logic [47:0] e);
        host.xfer(1'b1, a, n, l, 48'h0, q, err, done);
        check(q, e);
        check(48'({err, done, xfer_busy}), 48'h2);
    endtask : rd

    // settle time for the pin filters
    task automatic pins(input logic [2:0] p);
        host.set_pins(p);
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
    endtask : pins

    task automatic t_reset();
        check(48'(ctrl_active), 48'h0);
        check(48'({active_profile, profile_in_bank, pow_out}), 48'h0);
        check(48'(ftw_out), 48'h0);
        rd(ADDR_PROF_SEVEN, 6, 1'b0, 48'h0);
    endtask : t_reset

    // buffered writes stay hidden until the commit
    task automatic t_buffer();
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_PROF_FIVE + 5'(i), 6, pv[i], 1'b0);
        end
        pins(3'h7);
        check(48'({profile_in_bank, active_profile}), 48'hf);
        check(48'({pow_out, ftw_out}), 48'h0);
        host.commit();
        check(48'({pow_out, ftw_out}), pv[2] & MASK);
        rd(ADDR_PROF_SIX, 6, 1'b0, pv[1] & MASK);
        pins(3'h5);
        check(48'({pow_out, ftw_out}), pv[0] & MASK);
        pins(3'h2);
        check(48'({profile_in_bank, pow_out, ftw_out}), 48'h0);
    endtask : t_buffer

    // a low enable freezes every flop, the pin filters included
    task automatic t_freeze();
        @(posedge core_clk);
        clk_en <= 1'b0;
        pins(3'h6);
        check(48'({profile_in_bank, active_profile}), 48'h2);
        @(posedge core_clk);
        clk_en <= 1'b1;
        pins(3'h6);
        check(48'({profile_in_bank, active_profile}), 48'he);
        check(48'({pow_out, ftw_out}), pv[1] & MASK);
    endtask : t_freeze

    // refused addresses, and a storeless one of four bytes
    task automatic t_addr();
        host.xfer(1'b0, ADDR_UNUSED, 4, 1'b0, 48'h0, q, err, done);
        check(48'({err, xfer_busy}), 48'h2);
        host.xfer(1'b1, 5'h11, 4, 1'b0, 48'h0, q, err, done);
        check(48'({err, xfer_busy}), 48'h2);
        wr(5'h03, 4, 48'hffff_ffff, 1'b0);
        rd(5'h03, 4, 1'b0, 48'h0);
    endtask : t_addr

    // byte order acts at once; profile field waits for the commit
    task automatic t_ctrl();
        wr(ADDR_CTRL, 4, 48'h08d0_0000, 1'b0);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check(48'(ctrl_active), 48'h0080_0000);
        wr(ADDR_PROF_FIVE, 6, 48'h0abc_def0_1234, 1'b1);
        host.commit();
        check(48'({ctrl_active, active_profile}), 48'({32'h08d0_0000, 3'h5}));
        check(48'({pow_out, ftw_out}), 48'h0abc_def0_1234);
        rd(ADDR_CTRL, 4, 1'b1, 48'h08d0_0000);
    endtask : t_ctrl

    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        err_count = 0;
        samples_checked = 0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        t_reset();
        t_buffer();
        t_freeze();
        t_addr();
        t_ctrl();
        test_done();
    end

    // the whole run needs well under 2000 cycles
    initial begin
        #1000000;
        err_count++;
        test_done();
    end
endmodule : dds_profile_register_bank_tb_top
